// [rtl/sctq_core.sv]
// State capture control with sample qualifiers, pre-event memory and trigger stack
`timescale 1ns/1ps
module sctq_core (
   // Clock and reset
   input  wire logic                        clock_in,
   input  wire logic                        rst_n_in,
   // APB slave
   input  wire logic                        psel_in,
   input  wire logic                        penable_in,
   input  wire logic                        pwrite_in,
   input  wire logic [11:0]                 paddr_in,
   input  wire logic [31:0]                 pwdata_in,
   output logic      [31:0]                 prdata_out,
   output logic                             pready_out,
   output logic                             pslverr_out,
   // Probe pins from circuit under test
   input  wire logic                        sample_clk_in,
   input  wire logic [sctq_pkg::DATA_W-1:0] probe_data_in,
   input  wire logic [2:0]                  probe_qualifier_line_one_in,
   input  wire logic [2:0]                  probe_qualifier_line_two_in,
   input  wire logic                        rear_ext_in,
   input  wire logic                        link_in,
   // Status
   output logic [sctq_pkg::LVL_W-1:0]       level_out,
   output logic                             triggered_out,
   output logic                             done_out,
   output logic                             stalled_sample_warning_out
);
   localparam int DW = sctq_pkg::DATA_W;
   localparam int EW = sctq_pkg::EXT_W;
   localparam int NL = sctq_pkg::LEVELS;
   localparam int AW = sctq_pkg::ADDR_W;
   localparam int CW = sctq_pkg::CNT_W;
   localparam logic [AW-1:0] LAST_ADR = AW'(sctq_pkg::MEM_DEPTH - 1);
   localparam logic [AW-1:0] PRE_LIM  = AW'(sctq_pkg::PRE_MAX);
   // Stored words, trigger word included, of a full memory
   localparam logic [AW-1:0] FULL_CNT = AW'(sctq_pkg::MEM_DEPTH);

   // ==========================================
   // Input synchronisers
   // One shared sampling point keeps probe words whole

   logic [DW+EW+1:0] sync1_reg, sync2_reg;
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= {sample_clk_in, link_in, rear_ext_in,
                       probe_qualifier_line_two_in[2], probe_qualifier_line_one_in[2],
                       probe_qualifier_line_two_in[1], probe_qualifier_line_one_in[1],
                       probe_qualifier_line_two_in[0], probe_qualifier_line_one_in[0],
                       probe_data_in};
         sync2_reg <= sync1_reg;
      end
   end
   // Data is taken one flop late so it is stable at the detected clock edge
   logic [DW+EW+1:0] samp_reg;
   logic             sclk_d_reg;
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         samp_reg   <= '0;
         sclk_d_reg <= 1'b0;
      end else begin
         samp_reg   <= sync2_reg;
         sclk_d_reg <= sync2_reg[DW+EW+1];
      end
   end
   logic          edge_w;
   logic [DW-1:0] word_w;
   logic [EW-1:0] ext_w;
   assign edge_w = sync2_reg[DW+EW+1] & ~sclk_d_reg;
   assign word_w = samp_reg[DW-1:0];
   // A,A,B,B,C,C,E order; linkage bit stays out of the external field
   assign ext_w  = samp_reg[DW+EW-1:DW];

   // ==========================================
   // Pattern storage: index 0..15 trigger levels, 16..17 qualifiers
   logic [DW-1:0]  pat_dat [NL+2];
   logic [DW-1:0]  pat_care[NL+2];
   logic [EW-1:0]  ext_dat [NL+2];
   logic [EW-1:0]  ext_care[NL+2];
   logic [2:0]     lvl_mode[NL];
   logic [11:0]    lvl_cnt [NL];

   function automatic logic pat_hit(input logic [DW-1:0] w, input logic [EW-1:0] e,
                                    input logic [DW-1:0] d, input logic [DW-1:0] c,
                                    input logic [EW-1:0] ed, input logic [EW-1:0] ec);
      pat_hit = (((w ^ d) & c) == '0) && (((e ^ ed) & ec) == '0);
   endfunction

   // ==========================================
   // Registers
   logic             arm_reg, qen0_reg, qen1_reg;
   logic [3:0]       last_lvl_reg;
   logic [AW-1:0]    pre_reg;
   logic [15:0]      slowto_reg;
   logic [4:0]       qsel_reg;
   logic [AW-1:0]    memadr_reg;
   logic             apb_wr, apb_rd;

   // Writes land at the access edge only
   assign apb_wr = psel_in & penable_in & pwrite_in;
   assign apb_rd = psel_in & penable_in & ~pwrite_in;

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         qen0_reg     <= 1'b0;
         qen1_reg     <= 1'b0;
         last_lvl_reg <= '0;
         pre_reg      <= sctq_pkg::PRE_RST;
         slowto_reg   <= sctq_pkg::SLOWTO_RST;
         qsel_reg     <= '0;
         memadr_reg   <= '0;
      end else if (apb_wr) begin
         case (paddr_in)
            sctq_pkg::OFF_CTRL: begin
               // Disabling keeps the stored pattern
               qen0_reg     <= pwdata_in[sctq_pkg::CTRL_QEN0_BIT];
               qen1_reg     <= pwdata_in[sctq_pkg::CTRL_QEN1_BIT];
               last_lvl_reg <= pwdata_in[sctq_pkg::CTRL_LAST_LSB +: 4];
            end
            // Low 10 bits above the limit saturate; higher bits are ignored
            sctq_pkg::OFF_PRE: pre_reg <= (pwdata_in[AW-1:0] > PRE_LIM) ? PRE_LIM
                                                                        : pwdata_in[AW-1:0];
            sctq_pkg::OFF_SLOWTO: slowto_reg <= pwdata_in[15:0];
            sctq_pkg::OFF_QSEL:   qsel_reg   <= pwdata_in[4:0];
            sctq_pkg::OFF_MEMADR: memadr_reg <= pwdata_in[AW-1:0];
            default: ;
         endcase
      end
   end

   logic [4:0] pidx;
   assign pidx = qsel_reg[sctq_pkg::QSEL_QUAL_BIT] ? (5'(NL) + {4'h0, qsel_reg[0]}) : qsel_reg;

   // Pattern tables have no reset: program them before arming
   always_ff @(posedge clock_in) begin
      if (apb_wr) begin
         case (paddr_in)
            sctq_pkg::OFF_QDAT_LO:  pat_dat[pidx][31:0]   <= pwdata_in;
            sctq_pkg::OFF_QDAT_HI:  pat_dat[pidx][DW-1:32] <= pwdata_in[DW-33:0];
            sctq_pkg::OFF_QCARE_LO: pat_care[pidx][31:0]  <= pwdata_in;
            sctq_pkg::OFF_QCARE_HI: pat_care[pidx][DW-1:32] <= pwdata_in[DW-33:0];
            sctq_pkg::OFF_QEXT: begin
               ext_dat[pidx]  <= pwdata_in[EW-1:0];
               ext_care[pidx] <= pwdata_in[sctq_pkg::QEXT_CARE_LSB +: EW];
               if (!qsel_reg[sctq_pkg::QSEL_QUAL_BIT]) begin
                  lvl_mode[qsel_reg[3:0]] <= pwdata_in[sctq_pkg::QEXT_MODE_LSB +: 3];
                  lvl_cnt[qsel_reg[3:0]]  <= pwdata_in[31:20];
               end
            end
            default: ;
         endcase
      end
   end

   // ==========================================
   // Sample qualification
   logic q0_hit, q1_hit, store_ok;
   assign q0_hit   = pat_hit(word_w, ext_w, pat_dat[NL], pat_care[NL], ext_dat[NL], ext_care[NL]);
   assign q1_hit   = pat_hit(word_w, ext_w, pat_dat[NL+1], pat_care[NL+1], ext_dat[NL+1], ext_care[NL+1]);
   assign store_ok = (!qen0_reg && !qen1_reg) || (qen0_reg && q0_hit) || (qen1_reg && q1_hit);

   // ==========================================
   // Trigger stack sequencer
   sctq_pkg::sctq_state_t state_reg;
   logic [3:0]    lvl_reg;
   logic [CW-1:0] dcnt_reg;
   logic          lvl_hit, advance;
   sctq_pkg::sctq_mode_t cur_mode;
   logic [CW-1:0] n_w;
   assign lvl_hit  = pat_hit(word_w, ext_w, pat_dat[lvl_reg], pat_care[lvl_reg],
                             ext_dat[lvl_reg], ext_care[lvl_reg]);
   assign cur_mode = sctq_pkg::sctq_mode_t'(lvl_mode[lvl_reg]);
   assign n_w      = CW'(lvl_cnt[lvl_reg]);

   // Level count: sample edges since the previous match (matching edges only in OCCURS mode), first edge is one
   always_comb begin
      advance = 1'b0;
      if (lvl_reg == 4'h0) begin
         advance = lvl_hit;
      end else begin
         case (cur_mode)
            sctq_pkg::SCTQ_AFTER:  advance = lvl_hit && (dcnt_reg + 1'b1 > n_w);
            sctq_pkg::SCTQ_BEFORE: advance = lvl_hit && (dcnt_reg + 1'b1 < n_w);
            sctq_pkg::SCTQ_ON:     advance = lvl_hit && (dcnt_reg + 1'b1 == n_w);
            sctq_pkg::SCTQ_NOT_ON: advance = !lvl_hit && (dcnt_reg + 1'b1 == n_w);
            sctq_pkg::SCTQ_OCCURS: advance = lvl_hit && (dcnt_reg + 1'b1 == n_w);
            default:               advance = 1'b0;
         endcase
      end
   end

   logic arm_w;
   assign arm_w = apb_wr && (paddr_in == sctq_pkg::OFF_CTRL) && pwdata_in[sctq_pkg::CTRL_ARM_BIT];

   // Capture memory and pointers
   logic [DW-1:0] mem [sctq_pkg::MEM_DEPTH];
   logic [AW-1:0] wptr_reg, pre_cnt_reg, post_cnt_reg, trig_adr_reg, start_adr_reg;
   logic          do_store, trig_now;
   assign trig_now = (state_reg == sctq_pkg::SCTQ_SEQ) && edge_w && advance && (lvl_reg == last_lvl_reg);
   // A full memory takes no more words, so the oldest kept word survives
   assign do_store = edge_w && (store_ok || trig_now) &&
                     ((state_reg == sctq_pkg::SCTQ_POST && post_cnt_reg != FULL_CNT) ||
                      (state_reg == sctq_pkg::SCTQ_SEQ && (pre_reg != '0 || trig_now)));
   function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] a);
      wrap_inc = (a == LAST_ADR) ? '0 : a + 1'b1;
   endfunction

   // No reset here: only words already written are read back
   always_ff @(posedge clock_in) begin
      if (do_store) begin
         mem[wptr_reg] <= word_w;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= sctq_pkg::SCTQ_IDLE;
         lvl_reg   <= '0;
         dcnt_reg  <= '0;
      end else if (arm_w) begin
         state_reg <= sctq_pkg::SCTQ_SEQ;
         lvl_reg   <= '0;
         dcnt_reg  <= '0;
      end else if (state_reg == sctq_pkg::SCTQ_SEQ && edge_w) begin
         if (trig_now) begin
            state_reg <= sctq_pkg::SCTQ_POST;
         end else if (advance) begin
            lvl_reg  <= lvl_reg + 1'b1;
            dcnt_reg <= '0;
         end else if (lvl_reg != 4'h0 && cur_mode == sctq_pkg::SCTQ_OCCURS) begin
            if (lvl_hit) dcnt_reg <= dcnt_reg + 1'b1;
         end else if (dcnt_reg != '1) begin
            dcnt_reg <= dcnt_reg + 1'b1;
         end
      end else if (state_reg == sctq_pkg::SCTQ_POST && post_cnt_reg == FULL_CNT) begin
         state_reg <= sctq_pkg::SCTQ_DONE;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wptr_reg      <= '0;
         pre_cnt_reg   <= '0;
         post_cnt_reg  <= '0;
         trig_adr_reg  <= '0;
         start_adr_reg <= '0;
      end else if (arm_w) begin
         wptr_reg      <= '0;
         pre_cnt_reg   <= '0;
         post_cnt_reg  <= '0;
         start_adr_reg <= '0;
      end else if (do_store) begin
         wptr_reg <= wrap_inc(wptr_reg);
         if (trig_now) begin
            // Short pre-history is accepted as is
            trig_adr_reg <= wptr_reg;
            // The trigger word is one of the stored words
            post_cnt_reg <= pre_cnt_reg + 1'b1;
         end else if (state_reg == sctq_pkg::SCTQ_POST) begin
            post_cnt_reg <= post_cnt_reg + 1'b1;
         end else if (pre_cnt_reg == pre_reg) begin
            // Oldest pre-event word is dropped to honour the bound
            start_adr_reg <= wrap_inc(start_adr_reg);
         end else begin
            pre_cnt_reg <= pre_cnt_reg + 1'b1;
         end
      end
   end

   // ==========================================
   // Slow clock watchdog
   // Holds at the limit instead of wrapping, so the warning stays up

   logic [15:0] idle_reg;
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         idle_reg <= '0;
         stalled_sample_warning_out <= 1'b0;
      end else if (edge_w || state_reg != sctq_pkg::SCTQ_SEQ) begin
         idle_reg <= '0;
         stalled_sample_warning_out <= 1'b0;
      end else if (idle_reg >= slowto_reg) begin
         stalled_sample_warning_out <= 1'b1;
      end else begin
         idle_reg <= idle_reg + 1'b1;
      end
   end

   // ==========================================
   // Status outputs and APB read
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         level_out     <= '0;
         triggered_out <= 1'b0;
         done_out      <= 1'b0;
      end else begin
         // Flags follow the state one clock later
         level_out     <= lvl_reg;
         triggered_out <= (state_reg == sctq_pkg::SCTQ_POST) || (state_reg == sctq_pkg::SCTQ_DONE);
         done_out      <= (state_reg == sctq_pkg::SCTQ_DONE);
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prdata_out  <= '0;
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         // Answer in the access cycle: never a wait state
         pready_out  <= psel_in & ~penable_in;
         pslverr_out <= 1'b0;
         if (psel_in & ~penable_in & ~pwrite_in) begin
            case (paddr_in)
               sctq_pkg::OFF_CTRL:     prdata_out <= {24'h0, last_lvl_reg, 1'b0, qen1_reg, qen0_reg, 1'b0};
               sctq_pkg::OFF_STATUS:   prdata_out <= {22'h0, stalled_sample_warning_out, done_out,
                                                      triggered_out, state_reg, lvl_reg, 1'b0};
               sctq_pkg::OFF_PRE:      prdata_out <= {22'h0, pre_reg};
               sctq_pkg::OFF_SLOWTO:   prdata_out <= {16'h0, slowto_reg};
               sctq_pkg::OFF_COUNT:    prdata_out <= {22'h0, post_cnt_reg};
               sctq_pkg::OFF_TRIGADR:  prdata_out <= {22'h0, trig_adr_reg};
               sctq_pkg::OFF_STARTADR: prdata_out <= {22'h0, start_adr_reg};
               sctq_pkg::OFF_QSEL:     prdata_out <= {27'h0, qsel_reg};
               sctq_pkg::OFF_MEMADR:   prdata_out <= {22'h0, memadr_reg};
               sctq_pkg::OFF_MEM_LO:   prdata_out <= mem[memadr_reg][31:0];
               sctq_pkg::OFF_MEM_HI:   prdata_out <= {16'h0, mem[memadr_reg][DW-1:32]};
               default: begin
                  prdata_out  <= '0;
                  pslverr_out <= 1'b1;
               end
            endcase
         end else if (psel_in & ~penable_in) begin
            prdata_out  <= '0;
            pslverr_out <= !(paddr_in <= sctq_pkg::OFF_MEM_HI && paddr_in[1:0] == 2'b00);
         end
      end
   end

   // Linkage pin is sampled but takes no part in qualification
   logic unused_w;
   assign unused_w = apb_rd ^ samp_reg[DW+EW] ^ arm_reg;

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) arm_reg <= 1'b0;
      else arm_reg <= arm_w;
   end
endmodule // sctq_core

// [rtl/sctq_pkg.sv]
// Package of constants and types for the state capture trigger qualifier
package sctq_pkg;
   // ==========================================
   // Widths and depths
   localparam int DATA_W       = 48;
   localparam int EXT_W        = 7;
   localparam int LEVELS       = 16;
   localparam int LVL_W        = 4;
   localparam int MEM_DEPTH    = 1000;
   localparam int ADDR_W       = 10;
   localparam int CNT_W        = 16;
   localparam int PRE_MAX      = 999;
   localparam int PRE_MAX_OLD  = 249;
   // ==========================================
   // Register map (byte offsets, word aligned)
   localparam logic [11:0] OFF_CTRL     = 12'h000;
   localparam logic [11:0] OFF_STATUS   = 12'h004;
   localparam logic [11:0] OFF_PRE      = 12'h008;
   localparam logic [11:0] OFF_SLOWTO   = 12'h00C;
   localparam logic [11:0] OFF_COUNT    = 12'h010;
   localparam logic [11:0] OFF_TRIGADR  = 12'h014;
   localparam logic [11:0] OFF_STARTADR = 12'h018;
   localparam logic [11:0] OFF_QSEL     = 12'h01C;
   localparam logic [11:0] OFF_QDAT_LO  = 12'h020;
   localparam logic [11:0] OFF_QDAT_HI  = 12'h024;
   localparam logic [11:0] OFF_QCARE_LO = 12'h028;
   localparam logic [11:0] OFF_QCARE_HI = 12'h02C;
   localparam logic [11:0] OFF_QEXT     = 12'h030;
   localparam logic [11:0] OFF_MEMADR   = 12'h034;
   localparam logic [11:0] OFF_MEM_LO   = 12'h038;
   localparam logic [11:0] OFF_MEM_HI   = 12'h03C;
   // QSEL field: bit 4 picks the qualifier bank, bits 3:0 the stack level
   localparam int QSEL_QUAL_BIT = 4;
   // CTRL fields
   localparam int CTRL_ARM_BIT  = 0;
   localparam int CTRL_QEN0_BIT = 1;
   localparam int CTRL_QEN1_BIT = 2;
   localparam int CTRL_LAST_LSB = 4;
   // QEXT fields: ext data [6:0], ext care [14:8], mode [18:16], count [31:20]; mode and count for stack levels only
   localparam int QEXT_CARE_LSB = 8;
   localparam int QEXT_MODE_LSB = 16;
   // Reset values
   localparam logic [15:0] SLOWTO_RST = 16'hFFFF;
   localparam logic [9:0]  PRE_RST    = 10'h000;
   // ==========================================
   // Delay modes of stack levels 1..15
   typedef enum logic [2:0] {
      SCTQ_AFTER  = 3'b000,
      SCTQ_NOT_ON = 3'b001,
      SCTQ_BEFORE = 3'b010,
      SCTQ_ON     = 3'b011,
      SCTQ_OCCURS = 3'b100
   } sctq_mode_t;
   typedef enum logic [1:0] {
      SCTQ_IDLE  = 2'b00,
      SCTQ_SEQ   = 2'b01,
      SCTQ_POST  = 2'b10,
      SCTQ_DONE  = 2'b11
   } sctq_state_t;
endpackage

// [verif/sctq_core_checker.sv]
// Port checker for the trigger qualifier core
`timescale 1ns/1ps
module sctq_core_checker (
   // Clock and reset
   input wire logic                       clock_in,
   input wire logic                       rst_n_in,
   // APB
   input wire logic                       psel_in,
   input wire logic                       penable_in,
   input wire logic                       pwrite_in,
   input wire logic [11:0]                paddr_in,
   input wire logic [31:0]                pwdata_in,
   input wire logic                       pready_out,
   input wire logic                       pslverr_out,
   // Probe side and status
   input wire logic                       sample_clk_in,
   input wire logic [sctq_pkg::LVL_W-1:0] level_out,
   input wire logic                       triggered_out,
   input wire logic                       done_out,
   input wire logic                       stalled_sample_warning_out
);
   // ==========
   // Cycles since the raw sample clock changed, saturating
   logic       clk_seen_reg;
   logic [3:0] quiet_reg;
   logic       arm_wr;
   assign arm_wr = psel_in && penable_in && pwrite_in && paddr_in == sctq_pkg::OFF_CTRL && pwdata_in[0];
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         clk_seen_reg <= 1'b0;
         quiet_reg    <= 4'h0;
      end else begin
         clk_seen_reg <= sample_clk_in;
         quiet_reg    <= (sample_clk_in != clk_seen_reg) ? 4'h0 : (quiet_reg == 4'hF ? 4'hF : quiet_reg + 4'h1);
      end
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   // ==========
   // Assertions
   chk_ready_setup: assert property (psel_in && !penable_in |=> pready_out)
      else $error("no ready one cycle after setup");
   chk_ready_once: assert property (pready_out |=> !pready_out)
      else $error("ready held longer than one cycle");
   chk_err_ready: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
   chk_done_trig: assert property (done_out |-> triggered_out)
      else $error("done without trigger");
   chk_trig_hold: assert property (triggered_out && !arm_wr && !$past(arm_wr) |=> triggered_out)
      else $error("trigger flag dropped without arming");
   chk_trig_edge: assert property ($rose(triggered_out) |-> quiet_reg <= 4'h8)
      else $error("trigger not tied to a sample edge");
   chk_warn_quiet: assert property ($rose(stalled_sample_warning_out) |-> quiet_reg >= 4'h4)
      else $error("warning while sample clock moves");
   chk_warn_clear: assert property (stalled_sample_warning_out && $rose(sample_clk_in)
      |-> ##[1:8] !stalled_sample_warning_out) else $error("warning kept after clock resumed");
   chk_level_step: assert property (level_out != $past(level_out)
      |-> level_out == $past(level_out) + 4'h1 || level_out == 4'h0) else $error("level skipped");
   cover property ($rose(triggered_out));
   cover property ($rose(done_out));
   cover property ($rose(stalled_sample_warning_out));
   cover property (pslverr_out);
endmodule // sctq_core_checker

bind sctq_core sctq_core_checker sctq_core_checker_inst (.*);

// [verif/sctq_cut_model.sv]
// Circuit under test model: a counter on the probe channels
`timescale 1ns/1ps
module sctq_cut_model #(
   parameter int HALF_NS = 16
) (
   // Control from the bench
   input  wire logic   run_in,
   // Probe pins
   output logic        sample_clk_out,
   output logic [47:0] probe_data_out
);
   // Clock stands low between runs; data move on the falling edge, away from sampling
   initial begin
      sample_clk_out = 1'b0;
      probe_data_out = 48'h0;
      forever begin
         if (run_in !== 1'b1) begin
            sample_clk_out = 1'b0;
            probe_data_out = 48'h0;
            @(posedge run_in);
            // Keeps sample clock edges off the bench clock edges
            #1;
         end
         #(HALF_NS) sample_clk_out = 1'b1;
         #(HALF_NS) sample_clk_out = 1'b0;
         probe_data_out = {40'h0, probe_data_out[7:0] + 8'h01};
      end
   end
endmodule // sctq_cut_model

// [verif/sctq_core_tb.sv]
// Self-checking bench of the trigger qualifier core
`timescale 1ns/1ps
module sctq_core_tb;
   logic        clock_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        psel_in = 1'b0;
   logic        penable_in = 1'b0;
   logic        pwrite_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0;
   logic [31:0] prdata_out, q, t, s, d;
   logic        pready_out, pslverr_out, err, sample_clk_in;
   logic        run = 1'b0;
   logic [47:0] probe_data_in;
   logic [2:0]  probe_qualifier_line_one_in = 3'h0;
   logic [2:0]  probe_qualifier_line_two_in = 3'h0;
   logic        rear_ext_in = 1'b0;
   logic        link_in = 1'b1;
   logic [3:0]  level_out;
   logic        triggered_out, done_out, stalled_sample_warning_out;
   int          n_errors = 0;
   int          comparisons = 0;
   always #2 clock_in = ~clock_in;
   sctq_cut_model sctq_cut_model_inst (.run_in(run), .sample_clk_out(sample_clk_in), .probe_data_out(probe_data_in));
   sctq_core sctq_core_inst (.*);
   // ==========
   // Common tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic hang();
      n_errors++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      final_report();
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dw);
      int i;
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= dw;
      @(posedge clock_in);
      penable_in <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge clock_in);
         if (pready_out === 1'b1) break;
      end
      if (i == 16) hang();
      q = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clock_in);
   endtask
   task automatic rdmem(input logic [31:0] a);
      apb(1'b1, sctq_pkg::OFF_MEMADR, a % 32'd1000);
      apb(1'b0, sctq_pkg::OFF_MEM_LO, 32'h0);
   endtask
   task automatic pat(input logic [4:0] sel, input logic [31:0] dat, input logic [31:0] care, input logic [31:0] ext);
      apb(1'b1, sctq_pkg::OFF_QSEL, {27'h0, sel});
      apb(1'b1, sctq_pkg::OFF_QDAT_LO, dat);
      apb(1'b1, sctq_pkg::OFF_QDAT_HI, 32'h0);
      apb(1'b1, sctq_pkg::OFF_QCARE_LO, care);
      apb(1'b1, sctq_pkg::OFF_QCARE_HI, 32'h0);
      apb(1'b1, sctq_pkg::OFF_QEXT, ext);
   endtask
   // Stopping the model first makes every run start from word zero
   task automatic arm(input logic [31:0] ctrl);
      int i;
      run <= 1'b0;
      for (i = 0; i < 40 && probe_data_in !== 48'h0; i++) @(posedge clock_in);
      apb(1'b1, sctq_pkg::OFF_CTRL, ctrl);
      run <= 1'b1;
   endtask
   task automatic wait_on(input int sel, input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         @(posedge clock_in);
         if ((sel == 0 && triggered_out === 1'b1) || (sel == 1 && done_out === 1'b1) ||
             (sel == 2 && stalled_sample_warning_out === 1'b1) || (sel == 3 && level_out === 4'h1)) return;
      end
      hang();
   endtask
   // ==========
   // Scenarios
   task automatic t_regs();
      apb(1'b0, sctq_pkg::OFF_SLOWTO, 32'h0);
      chk(q, 32'h0000FFFF);
      apb(1'b0, 12'h040, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, sctq_pkg::OFF_PRE, 32'h3E8);
      apb(1'b0, sctq_pkg::OFF_PRE, 32'h0);
      chk(q, 32'h3E7);
      $display("test regs done");
   endtask
   task automatic t_qual();
      int i;
      pat(5'h00, 32'h32, 32'hFF, 32'h0);
      pat(5'h10, 32'h40, 32'hF0, 32'h0);
      pat(5'h11, 32'h5F, 32'hFF, 32'h0);
      apb(1'b1, sctq_pkg::OFF_PRE, 32'h0);
      arm(32'h7);
      wait_on(0, 3000);
      for (i = 0; i < 200; i++) begin
         apb(1'b0, sctq_pkg::OFF_COUNT, 32'h0);
         if (q >= 32'd18) break;
      end
      if (i == 200) hang();
      apb(1'b0, sctq_pkg::OFF_TRIGADR, 32'h0);
      t = q;
      rdmem(t);
      chk(q, 32'h32);
      rdmem(t + 32'd1);
      chk(q, 32'h40);
      rdmem(t + 32'd16);
      chk(q, 32'h4F);
      rdmem(t + 32'd17);
      chk(q, 32'h5F);
      $display("test qualifiers done");
   endtask
   task automatic t_pre(input logic [31:0] pre, input logic [31:0] lo, input logic [31:0] hi);
      pat(5'h00, 32'h40, 32'hFF, 32'h0);
      apb(1'b1, sctq_pkg::OFF_PRE, pre);
      arm(32'h1);
      wait_on(1, 12000);
      apb(1'b0, sctq_pkg::OFF_COUNT, 32'h0);
      chk(q, 32'd1000);
      apb(1'b0, sctq_pkg::OFF_TRIGADR, 32'h0);
      t = q;
      apb(1'b0, sctq_pkg::OFF_STARTADR, 32'h0);
      s = q;
      d = (t + 32'd1000 - s) % 32'd1000;
      chk({31'h0, d >= lo && d <= hi}, 32'h1);
      rdmem(s);
      chk(q, (32'h40 - d) & 32'hFF);
      $display("test pre-event depth %0d done", pre);
   endtask
   task automatic t_stack(input logic [2:0] mode, input logic [11:0] n, input logic [31:0] dat, input logic [31:0] exp);
      pat(5'h00, 32'h10, 32'hFF, 32'h0);
      pat(5'h01, dat, 32'hF0, {n, 1'b0, mode, 16'h0});
      apb(1'b1, sctq_pkg::OFF_PRE, 32'h0);
      arm(32'h11);
      wait_on(0, 3000);
      apb(1'b0, sctq_pkg::OFF_STATUS, 32'h0);
      chk({31'h0, q[7]}, 32'h1);
      apb(1'b0, sctq_pkg::OFF_TRIGADR, 32'h0);
      rdmem(q);
      if (exp != 32'hFFFF) chk(q, exp);
      $display("test stack mode %0d done", mode);
   endtask
   task automatic t_stall();
      pat(5'h00, 32'h10, 32'hFF, 32'h0);
      pat(5'h01, 32'hAA, 32'hFF, 32'h0);
      apb(1'b1, sctq_pkg::OFF_SLOWTO, 32'd20);
      arm(32'h11);
      wait_on(3, 3000);
      run <= 1'b0;
      wait_on(2, 400);
      chk({28'h0, level_out}, 32'h1);
      apb(1'b0, sctq_pkg::OFF_STATUS, 32'h0);
      chk(q & 32'h3FE, 32'h222);
      run <= 1'b1;
      wait_on(0, 3000);
      chk({31'h0, stalled_sample_warning_out}, 32'h0);
      $display("test slow clock done");
   endtask
   task automatic t_ext();
      // Needs E and A2 high with A1 low; the linkage pin moves but must not matter
      rear_ext_in                 <= 1'b1;
      probe_qualifier_line_two_in <= 3'h1;
      link_in                     <= 1'b0;
      pat(5'h00, 32'h10, 32'hFF, 32'h4342);
      apb(1'b1, sctq_pkg::OFF_PRE, 32'h0);
      arm(32'h1);
      wait_on(0, 3000);
      apb(1'b0, sctq_pkg::OFF_TRIGADR, 32'h0);
      rdmem(q);
      chk(q, 32'h10);
      $display("test external qualifiers done");
   endtask
   initial begin
      repeat (6) @(posedge clock_in);
      rst_n_in <= 1'b1;
      @(posedge clock_in);
      t_regs();
      t_qual();
      t_pre(32'd0, 32'd0, 32'd0);
      t_pre(32'd3, 32'd3, 32'd3);
      t_pre(32'd999, 32'd1, 32'd64);
      t_ext();
      t_stack(sctq_pkg::SCTQ_AFTER, 12'd2, 32'h10, 32'h13);
      t_stack(sctq_pkg::SCTQ_NOT_ON, 12'd2, 32'h20, 32'h12);
      t_stack(sctq_pkg::SCTQ_BEFORE, 12'd3, 32'h10, 32'h11);
      t_stack(sctq_pkg::SCTQ_ON, 12'd2, 32'h10, 32'h12);
      t_stack(sctq_pkg::SCTQ_OCCURS, 12'd3, 32'h10, 32'h13);
      t_stall();
      final_report();
   end
endmodule // sctq_core_tb
